// file: logic/esl_pkg.sv
// Constants and state types for the configuration self-load block
// Summary of operation
// [RL1] Channel block-enable overrides apply only while override-enable bit 7 is set.
// [RL2] Bits 6-0 enable blocks: all ones enables every block, all zeros disables.
// [RL3] Bias register bits 5-3 hold read/write bias current; 001 is recommended.
// [RL4] Self-load mode is entered only when the mode strap samples level L1.
// [RL5] The EEPROM load runs at most once after power-up, never again.
// [RL6] In primary mode stay idle until the load request goes low.
// [RL7] On request, become bus primary and read the EEPROM at address byte 0xA0.
// [RL8] After a successful read drive the load-complete output low.
// [RL9] Secondary register access stays available before, during and after loading.
// [RL10] A foreign primary touching registers during loading must support arbitration.
// [RL11] The EEPROM answers at address byte 0xA0 and runs at 400 kHz.
// [RL12] A 2 kb EEPROM of 256 bytes is recommended.
// [RL13] Tie the first device's load request low for automatic loading.
// [RL14] A microcontroller may instead drive the first load request low.
// [RL15] A supervisor may watch the last load-complete output, or leave it open.
// [RL16] With receiver detect disabled the device is interface agnostic.
// [RL17] In a chain each load-complete output feeds the next load request.
// [RL18] Loaded values act exactly like the same values written by the secondary bus.
package esl_pkg;

  // Register map
  localparam logic [7:0] REG_PD_OVR      = 8'h05;
  localparam logic [7:0] REG_BIAS        = 8'h06;
  localparam logic [7:0] PD_OVR_RST      = 8'h7f;
  localparam logic [7:0] BIAS_RST        = 8'h20;
  localparam int         OVR_EN_BIT      = 7;
  localparam int         DEV_EN_MSB      = 6;
  localparam int         BIAS_MSB        = 5;
  localparam int         BIAS_LSB        = 3;
  localparam logic [2:0] BIAS_BEST       = 3'h1;

  // Strap, EEPROM and bus constants
  localparam logic [1:0] MODE_L1         = 2'h1;
  localparam logic [7:0] EE_ADDR_WR      = 8'ha0;
  localparam logic [7:0] EE_ADDR_RD      = 8'ha1;
  localparam logic [7:0] EE_FIRST_WORD   = 8'h00;
  localparam logic [6:0] SEC_ADDR_DEF    = 7'h18;
  localparam int         LOAD_LEN_DEF    = 8;

  // Timing: primary runs no faster than 400 kHz, quarter bit rounded up
  localparam int         CLK_KHZ         = 50000;
  localparam int         BUS_MAX_KHZ     = 400;
  localparam int         QUARTER_CYC     = (CLK_KHZ + 4 * BUS_MAX_KHZ - 1) / (4 * BUS_MAX_KHZ);
  localparam logic [5:0] QUARTER_LAST    = 6'(QUARTER_CYC - 1);
  localparam logic [1:0] BOOT_SETTLE     = 2'h3;

  // Synchroniser lane layout and reset value (bus lines and request idle high)
  localparam int         SYNC_W          = 8;
  localparam logic [7:0] SYNC_RST        = 8'h23;

  typedef enum logic [2:0] {
    SLV_IDLE, SLV_ADDR, SLV_PTR, SLV_WR, SLV_ACK, SLV_RD, SLV_RACK, SLV_RDN
  } esl_slv_e;

  typedef enum logic [3:0] {
    MST_BOOT, MST_OFF, MST_IDLE, MST_FREE, MST_START, MST_RSTART, MST_BIT, MST_STOP, MST_DONE, MST_FAIL
  } esl_mst_e;

endpackage

// file: logic/esl_sync.sv
// Two-stage synchroniser for a vector of asynchronous inputs
`timescale 1ns/1ps
module esl_sync #(
  parameter int         W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         mclk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_d;

  // First stage feeds only the second stage
  always_comb
  begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_q   <= RST;
      sync_out <= RST;
    end
    else
    begin
      meta_q   <= meta_d;
      sync_out <= sync_d;
    end
  end

endmodule // esl_sync

// file: logic/esl_top.sv
// Self-load controller: two-wire secondary, EEPROM primary and channel registers
`timescale 1ns/1ps
module esl_top #(
  parameter logic [6:0] SEC_ADDR = esl_pkg::SEC_ADDR_DEF,
  parameter int         LOAD_LEN = esl_pkg::LOAD_LEN_DEF
) (
  input  wire logic       mclk,
  input  wire logic       reset_n,
  input  wire logic [1:0] mode_strap,
  input  wire logic       load_req_n,
  input  wire logic       power_down_input_a,
  input  wire logic       power_down_input_b,
  input  wire logic       rx_det_disable,
  input  wire logic       scl_i,
  output logic            scl_o,
  output logic            scl_oe,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  output logic            load_done_n,
  output logic [6:0]      blk_en_a,
  output logic [6:0]      blk_en_b,
  output logic [2:0]      bias_ctrl,
  output logic            rx_det_en
);

  localparam logic [7:0] LAST_IDX = 8'(LOAD_LEN + 2);

  logic [7:0] sy;
  logic       scl, sda, req_n, pd_a, pd_b, rxd_off;
  logic [1:0] mode;

  esl_sync #(.W(esl_pkg::SYNC_W), .RST(esl_pkg::SYNC_RST)) esl_sync_inst (
    .mclk     (mclk),
    .reset_n  (reset_n),
    .async_in ({mode_strap, load_req_n, power_down_input_a, power_down_input_b, rx_det_disable, scl_i, sda_i}),
    .sync_out (sy)
  );

  assign {mode, req_n, pd_a, pd_b, rxd_off, scl, sda} = sy;

  // Bus line history and condition detection
  logic prev_scl_q, prev_sda_q, busy_q, busy_d;
  logic start_c, stop_c, scl_rise, scl_fall;

  assign start_c  = scl & prev_scl_q & prev_sda_q & ~sda;
  assign stop_c   = scl & prev_scl_q & ~prev_sda_q & sda;
  assign scl_rise = scl & ~prev_scl_q;
  assign scl_fall = ~scl & prev_scl_q;

  always_comb
  begin
    busy_d = busy_q;
    if (start_c)
      busy_d = 1'b1;
    else if (stop_c)
      busy_d = 1'b0;
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      prev_scl_q <= 1'b1;
      prev_sda_q <= 1'b1;
      busy_q     <= 1'b0;
    end
    else
    begin
      prev_scl_q <= scl;
      prev_sda_q <= sda;
      busy_q     <= busy_d;
    end
  end

  // Channel registers; both bus roles share one write path
  logic [7:0] pd_ovr_q, pd_ovr_d, bias_q, bias_d;
  logic       s_we, m_we;
  logic [7:0] s_waddr, s_wdata, m_waddr, m_wdata;

  function automatic logic [7:0] reg_read(input logic [7:0] a, input logic [7:0] ovr, input logic [7:0] bi);
    case (a)
      esl_pkg::REG_PD_OVR: reg_read = ovr;
      esl_pkg::REG_BIAS:   reg_read = bi;
      default:             reg_read = 8'h00;
    endcase
  endfunction

  // Secondary write applied last so it wins a same-cycle collision
  always_comb
  begin
    pd_ovr_d = pd_ovr_q;
    bias_d   = bias_q;
    if (m_we && m_waddr == esl_pkg::REG_PD_OVR)
      pd_ovr_d = m_wdata;                          // [RL18]
    if (m_we && m_waddr == esl_pkg::REG_BIAS)
      bias_d = m_wdata;                            // [RL18]
    if (s_we && s_waddr == esl_pkg::REG_PD_OVR)
      pd_ovr_d = s_wdata;
    if (s_we && s_waddr == esl_pkg::REG_BIAS)
      bias_d = s_wdata;                            // [RL3]
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pd_ovr_q <= esl_pkg::PD_OVR_RST;
      bias_q   <= esl_pkg::BIAS_RST;
    end
    else
    begin
      pd_ovr_q <= pd_ovr_d;
      bias_q   <= bias_d;
    end
  end

  // Secondary engine: answers at SEC_ADDR at any time, even mid-load
  esl_pkg::esl_slv_e s_state_q, s_state_d, s_tgt_q, s_tgt_d;
  logic [7:0] s_shift_q, s_shift_d, s_ptr_q, s_ptr_d, s_byte;
  logic [2:0] s_bits_q, s_bits_d;
  logic       s_low_q, s_low_d;

  assign s_byte = {s_shift_q[6:0], sda};

  always_comb
  begin
    s_state_d = s_state_q;
    s_tgt_d   = s_tgt_q;
    s_shift_d = s_shift_q;
    s_ptr_d   = s_ptr_q;
    s_bits_d  = s_bits_q;
    s_low_d   = s_low_q;
    s_we      = 1'b0;
    s_waddr   = s_ptr_q;
    s_wdata   = s_byte;
    if (start_c)
    begin
      s_state_d = esl_pkg::SLV_ADDR;                // [RL9]
      s_bits_d  = 3'h0;
      s_low_d   = 1'b0;
    end
    else if (stop_c)
    begin
      s_state_d = esl_pkg::SLV_IDLE;
      s_low_d   = 1'b0;
    end
    else
      case (s_state_q)
        esl_pkg::SLV_ADDR, esl_pkg::SLV_PTR, esl_pkg::SLV_WR:
          if (scl_rise)
          begin
            s_shift_d = s_byte;
            s_bits_d  = s_bits_q + 3'h1;
            if (s_bits_q == 3'h7)
            begin
              s_state_d = esl_pkg::SLV_ACK;
              if (s_state_q == esl_pkg::SLV_ADDR)
              begin
                if (s_byte[7:1] != SEC_ADDR)
                  s_state_d = esl_pkg::SLV_IDLE;  // Not ours, stay silent
                s_tgt_d = s_byte[0] ? esl_pkg::SLV_RDN : esl_pkg::SLV_PTR;
              end
              else if (s_state_q == esl_pkg::SLV_PTR)
              begin
                s_ptr_d = s_byte;
                s_tgt_d = esl_pkg::SLV_WR;
              end
              else
              begin
                s_we    = 1'b1;
                s_ptr_d = s_ptr_q + 8'h01;
                s_tgt_d = esl_pkg::SLV_WR;
              end
            end
          end
        esl_pkg::SLV_ACK:
          if (scl_fall)
          begin
            if (!s_low_q)
              s_low_d = 1'b1;
            else if (s_tgt_q == esl_pkg::SLV_RDN)
            begin
              s_shift_d = reg_read(s_ptr_q, pd_ovr_q, bias_q);
              s_low_d   = ~s_shift_d[7];
              s_bits_d  = 3'h0;
              s_state_d = esl_pkg::SLV_RD;
            end
            else
            begin
              s_low_d   = 1'b0;
              s_bits_d  = 3'h0;
              s_state_d = s_tgt_q;
            end
          end
        esl_pkg::SLV_RD:
          if (scl_fall)
          begin
            s_bits_d = s_bits_q + 3'h1;
            if (s_bits_q == 3'h7)
            begin
              s_low_d   = 1'b0;
              s_state_d = esl_pkg::SLV_RACK;
            end
            else
            begin
              s_shift_d = {s_shift_q[6:0], 1'b0};
              s_low_d   = ~s_shift_q[6];
            end
          end
        esl_pkg::SLV_RACK:
          if (scl_rise)
          begin
            if (sda)
              s_state_d = esl_pkg::SLV_IDLE;        // Primary ended the read
            else
            begin
              s_ptr_d   = s_ptr_q + 8'h01;
              s_state_d = esl_pkg::SLV_RDN;
            end
          end
        esl_pkg::SLV_RDN:
          if (scl_fall)
          begin
            s_shift_d = reg_read(s_ptr_q, pd_ovr_q, bias_q);
            s_low_d   = ~s_shift_d[7];
            s_bits_d  = 3'h0;
            s_state_d = esl_pkg::SLV_RD;
          end
        default: s_state_d = s_state_q;
      endcase
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_state_q <= esl_pkg::SLV_IDLE;
      s_tgt_q   <= esl_pkg::SLV_PTR;
      s_shift_q <= 8'h00;
      s_ptr_q   <= 8'h00;
      s_bits_q  <= 3'h0;
      s_low_q   <= 1'b0;
    end
    else
    begin
      s_state_q <= s_state_d;
      s_tgt_q   <= s_tgt_d;
      s_shift_q <= s_shift_d;
      s_ptr_q   <= s_ptr_d;
      s_bits_q  <= s_bits_d;
      s_low_q   <= s_low_d;
    end
  end

  // Primary engine: one EEPROM read after power-up, quarter-bit sequenced
  esl_pkg::esl_mst_e m_state_q, m_state_d;
  logic [5:0] m_q_q, m_q_d;
  logic [1:0] m_ph_q, m_ph_d, boot_q, boot_d;
  logic [3:0] m_bits_q, m_bits_d;
  logic [7:0] m_idx_q, m_idx_d, m_shift_q, m_shift_d;
  logic       m_scl_low_q, m_scl_low_d, m_sda_low_q, m_sda_low_d, m_ok_q, m_ok_d;
  logic       tick, m_rd;

  // A released clock held low by another party stretches the quarter
  assign tick = (m_q_q == esl_pkg::QUARTER_LAST) && (m_scl_low_q || scl);
  assign m_rd = (m_idx_q > 8'h02);

  always_comb
  begin
    m_state_d   = m_state_q;
    m_q_d       = (tick || (!m_scl_low_q && !scl)) ? 6'h00 : m_q_q + 6'h01;
    m_ph_d      = m_ph_q;
    boot_d      = boot_q;
    m_bits_d    = m_bits_q;
    m_idx_d     = m_idx_q;
    m_shift_d   = m_shift_q;
    m_scl_low_d = m_scl_low_q;
    m_sda_low_d = m_sda_low_q;
    m_ok_d      = m_ok_q;
    m_we        = 1'b0;
    m_waddr     = m_idx_q - 8'h03;
    m_wdata     = m_shift_q;
    case (m_state_q)
      esl_pkg::MST_BOOT:
        if (boot_q == esl_pkg::BOOT_SETTLE)
          m_state_d = (mode == esl_pkg::MODE_L1) ? esl_pkg::MST_IDLE : esl_pkg::MST_OFF; // [RL4]
        else
          boot_d = boot_q + 2'h1;
      esl_pkg::MST_IDLE:
        if (!req_n)
          m_state_d = esl_pkg::MST_FREE;            // [RL6] [RL17]
      esl_pkg::MST_FREE:
      begin
        m_scl_low_d = 1'b0;
        m_sda_low_d = 1'b0;
        m_idx_d     = 8'h00;
        m_ph_d      = 2'h0;
        if (!busy_q && scl && sda && tick)
          m_state_d = esl_pkg::MST_START;
      end
      esl_pkg::MST_START:
        if (tick)
        begin
          if (m_ph_q == 2'h0)
          begin
            m_sda_low_d = 1'b1;
            m_ph_d      = 2'h1;
          end
          else
          begin
            m_scl_low_d = 1'b1;
            m_ph_d      = 2'h0;
            m_bits_d    = 4'h0;
            m_shift_d   = esl_pkg::EE_ADDR_WR;      // [RL7]
            m_state_d   = esl_pkg::MST_BIT;
          end
        end
      esl_pkg::MST_RSTART:
        if (tick)
        begin
          m_ph_d = m_ph_q + 2'h1;
          case (m_ph_q)
            2'h0: m_sda_low_d = 1'b0;
            2'h1: m_scl_low_d = 1'b0;
            2'h2: m_sda_low_d = 1'b1;
            default:
            begin
              m_scl_low_d = 1'b1;
              m_bits_d    = 4'h0;
              m_shift_d   = esl_pkg::EE_ADDR_RD;
              m_state_d   = esl_pkg::MST_BIT;
            end
          endcase
        end
      esl_pkg::MST_BIT:
        if (tick)
        begin
          m_ph_d = m_ph_q + 2'h1;
          case (m_ph_q)
            2'h0:
              if (m_bits_q == 4'h8)
                m_sda_low_d = m_rd && (m_idx_q != LAST_IDX);   // Nack ends the read
              else
                m_sda_low_d = !m_rd && !m_shift_q[7];
            2'h1: m_scl_low_d = 1'b0;
            2'h2:
              if (m_bits_q != 4'h8)
              begin
                if (!m_rd && !m_sda_low_q && !sda)
                begin
                  m_scl_low_d = 1'b0;                // Lost the bus, retry the load [RL10]
                  m_sda_low_d = 1'b0;
                  m_state_d   = esl_pkg::MST_FREE;
                end
                m_shift_d = {m_shift_q[6:0], sda};
              end
              else if (!m_rd && sda)
                m_ok_d = 1'b0;                     // EEPROM did not acknowledge
            default:
            begin
              m_scl_low_d = 1'b1;
              m_bits_d    = m_bits_q + 4'h1;
              if (m_bits_q == 4'h8)
              begin
                m_bits_d  = 4'h0;
                m_we      = m_rd;                  // [RL18]
                m_idx_d   = m_idx_q + 8'h01;
                m_shift_d = esl_pkg::EE_FIRST_WORD;
                if (!m_ok_q || m_idx_q == LAST_IDX)
                  m_state_d = esl_pkg::MST_STOP;
                else if (m_idx_q == 8'h01)
                  m_state_d = esl_pkg::MST_RSTART;
              end
            end
          endcase
        end
      esl_pkg::MST_STOP:
        if (tick)
        begin
          m_ph_d = m_ph_q + 2'h1;
          case (m_ph_q)
            2'h0: m_sda_low_d = 1'b1;
            2'h1: m_scl_low_d = 1'b0;
            2'h2:
            begin
              m_sda_low_d = 1'b0;
              m_state_d   = m_ok_q ? esl_pkg::MST_DONE : esl_pkg::MST_FAIL; // [RL8]
            end
            default: m_ph_d = 2'h0;
          endcase
        end
      // Done, fail and off are terminal: no second load after power-up
      esl_pkg::MST_DONE, esl_pkg::MST_FAIL, esl_pkg::MST_OFF:
        m_state_d = m_state_q;                     // [RL5]
      default: m_state_d = esl_pkg::MST_FAIL;
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      m_state_q   <= esl_pkg::MST_BOOT;
      m_q_q       <= 6'h00;
      m_ph_q      <= 2'h0;
      boot_q      <= 2'h0;
      m_bits_q    <= 4'h0;
      m_idx_q     <= 8'h00;
      m_shift_q   <= 8'h00;
      m_scl_low_q <= 1'b0;
      m_sda_low_q <= 1'b0;
      m_ok_q      <= 1'b1;
    end
    else
    begin
      m_state_q   <= m_state_d;
      m_q_q       <= m_q_d;
      m_ph_q      <= m_ph_d;
      boot_q      <= boot_d;
      m_bits_q    <= m_bits_d;
      m_idx_q     <= m_idx_d;
      m_shift_q   <= m_shift_d;
      m_scl_low_q <= m_scl_low_d;
      m_sda_low_q <= m_sda_low_d;
      m_ok_q      <= m_ok_d;
    end
  end

  // Registered pin drives and channel controls
  logic [6:0] blk_a_d, blk_b_d;

  always_comb
  begin
    if (pd_ovr_q[esl_pkg::OVR_EN_BIT])
    begin
      blk_a_d = pd_ovr_q[esl_pkg::DEV_EN_MSB:0];   // [RL1] [RL2]
      blk_b_d = pd_ovr_q[esl_pkg::DEV_EN_MSB:0];
    end
    else
    begin
      blk_a_d = {7{~pd_a}};                        // [RL1]
      blk_b_d = {7{~pd_b}};
    end
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      scl_o       <= 1'b0;
      sda_o       <= 1'b0;
      scl_oe      <= 1'b0;
      sda_oe      <= 1'b0;
      load_done_n <= 1'b1;
      blk_en_a    <= 7'h00;
      blk_en_b    <= 7'h00;
      bias_ctrl   <= 3'h0;
      rx_det_en   <= 1'b0;
    end
    else
    begin
      scl_o       <= 1'b0;
      sda_o       <= 1'b0;
      scl_oe      <= m_scl_low_q;
      sda_oe      <= m_sda_low_q | s_low_q;        // Both roles share the open-drain line [RL9]
      load_done_n <= (m_state_q != esl_pkg::MST_DONE); // [RL8]
      blk_en_a    <= blk_a_d;
      blk_en_b    <= blk_b_d;
      bias_ctrl   <= bias_q[esl_pkg::BIAS_MSB:esl_pkg::BIAS_LSB]; // [RL3]
      rx_det_en   <= ~rxd_off;                      // [RL16]
    end
  end

endmodule // esl_top

// file: bench/esl_top_chk.sv
// Port-level assertion checker for the self-load controller
`timescale 1ns/1ps
module esl_top_chk (
  input wire logic       mclk,
  input wire logic       reset_n,
  input wire logic [1:0] mode_strap,
  input wire logic       load_req_n,
  input wire logic       power_down_input_a,
  input wire logic       power_down_input_b,
  input wire logic       rx_det_disable,
  input wire logic       scl_i,
  input wire logic       scl_o,
  input wire logic       scl_oe,
  input wire logic       sda_i,
  input wire logic       sda_o,
  input wire logic       sda_oe,
  input wire logic       load_done_n,
  input wire logic [6:0] blk_en_a,
  input wire logic [6:0] blk_en_b,
  input wire logic [2:0] bias_ctrl,
  input wire logic       rx_det_en
);
  logic [1:0] hist_q;
  logic [1:0] hist_d;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  // Sticky: bit 0 request seen, bit 1 strap code seen
  always_comb
    hist_d = hist_q | {mode_strap == esl_pkg::MODE_L1, ~load_req_n};
  always_ff @(posedge mclk or negedge reset_n)
    if (!reset_n)
      hist_q <= 2'h0;
    else
      hist_q <= hist_d;

  chk_idle_no_req: assert property (!hist_q[0] |-> !scl_oe)
    else $error("primary clock driven without a load request");
  chk_strap_gate: assert property (!hist_q[1] |-> !scl_oe && load_done_n)
    else $error("primary active without the self-load strap");
  chk_done_sticky: assert property (!load_done_n |=> !load_done_n)
    else $error("load complete output released");
  chk_done_quiet: assert property (!load_done_n |-> !scl_oe)
    else $error("primary active again after completion");
  chk_done_cause: assert property ($fell(load_done_n) |-> hist_q == 2'h3)
    else $error("completion without request in self-load mode");
  chk_ovr_gate: assert property (blk_en_a != blk_en_b |->
    blk_en_a inside {7'h00, 7'h7f} && blk_en_b inside {7'h00, 7'h7f})
    else $error("halves differ while override pattern applied");
  chk_rxdet_follow: assert property ($stable(rx_det_disable)[*5] |-> rx_det_en == !rx_det_disable)
    else $error("receiver detect enable does not follow its pin");
  chk_scl_low_hold: assert property ($rose(scl_oe) |-> scl_oe[*8])
    else $error("primary clock low phase too short");
  chk_od_zero: assert property (!scl_o && !sda_o)
    else $error("open-drain data value not zero");
endmodule // esl_top_chk

bind esl_top esl_top_chk esl_top_chk_inst (
  .mclk, .reset_n, .mode_strap, .load_req_n, .power_down_input_a, .power_down_input_b,
  .rx_det_disable, .scl_i, .scl_o, .scl_oe, .sda_i, .sda_o, .sda_oe, .load_done_n,
  .blk_en_a, .blk_en_b, .bias_ctrl, .rx_det_en
);

// file: bench/esl_ee_model.sv
// Behavioural two-wire serial EEPROM of 256 bytes
`timescale 1ns/1ps
module esl_ee_model (
  input  wire logic scl,
  input  wire logic sda,
  output wire logic sda_oe
);
  localparam logic [6:0] DEV_ADDR = 7'h50; // Address byte 0xa0
  logic [7:0] mem [0:255]; // 2 kb as 256 bytes
  logic [7:0] sh;
  logic [7:0] ptr;
  logic [3:0] bc = 4'h0;
  logic [1:0] ph = 2'h3; // 0 address, 1 pointer, 2 read, 3 idle
  logic       rd;
  logic       drv = 1'b0;

  // Data moves a hold time after the clock falls, never while it is high
  assign #100 sda_oe = drv;

  // Start opens a frame, stop closes it
  always @(negedge sda)
    if (scl === 1'b1)
    begin
      ph = 2'h0;
      bc = 4'h0;
      drv = 1'b0;
    end
  always @(posedge sda)
    if (scl === 1'b1)
      ph = 2'h3;

  // Shift on the rising clock; a refused read byte ends the frame
  always @(posedge scl)
    if (ph != 2'h3)
    begin
      if (bc < 4'h8)
        sh = {sh[6:0], sda};
      else if (ph == 2'h2 && sda)
        ph = 2'h3;
      bc = bc + 4'h1;
    end

  // Acknowledge and send data on the falling clock
  always @(negedge scl)
    if (ph != 2'h3)
    begin
      rd = (bc == 4'h8 && ph == 2'h0) ? sh[0] : rd;
      if (bc == 4'h8 && ph == 2'h0 && sh[7:1] != DEV_ADDR)
        ph = 2'h3;
      if (bc == 4'h8 && ph == 2'h1)
        ptr = sh;
      if (bc == 4'h9)
      begin
        bc = 4'h0;
        ph = (ph == 2'h0) ? (rd ? 2'h2 : 2'h1) : ph;
        sh = mem[ptr];
        ptr = (ph == 2'h2) ? ptr + 8'h1 : ptr;
      end
      drv = (ph == 2'h2) ? (bc != 4'h8 && !sh[7]) : (bc == 4'h8 && ph != 2'h3);
    end
endmodule // esl_ee_model

// file: bench/tb_esl_top.sv
// Self-checking bench for the self-load controller
`timescale 1ns/1ps
module tb_esl_top;
  logic       mclk = 1'b0;
  logic       reset_n = 1'b0;
  logic [1:0] mode_strap = esl_pkg::MODE_L1;
  logic       load_req_n = 1'b1; // Driven as a microcontroller would
  logic       pd_a = 1'b0;
  logic       pd_b = 1'b0;
  logic       rx_dis = 1'b0;
  logic       m_scl = 1'b0;
  logic       m_sda = 1'b0;
  logic       scl_oe, sda_oe, load_done_n, rx_det_en;
  logic [6:0] blk_en_a, blk_en_b;
  logic [2:0] bias_ctrl;
  logic [7:0] rv;
  int         fail_count = 0;
  int         compares = 0;
  int         cyc = 0;
  int         busy = 0;
  int         seed = 32'hb8a9;
  wire        ee_oe;
  wire        scl = !(scl_oe | m_scl);
  wire        sda = !(sda_oe | m_sda | ee_oe);

  esl_top esl_top_inst (
    .mclk, .reset_n, .mode_strap, .load_req_n, .power_down_input_a(pd_a), .power_down_input_b(pd_b),
    .rx_det_disable(rx_dis), .scl_i(scl), .scl_o(), .scl_oe, .sda_i(sda), .sda_o(), .sda_oe,
    .load_done_n, .blk_en_a, .blk_en_b, .bias_ctrl, .rx_det_en);
  esl_ee_model esl_ee_model_inst (.scl, .sda, .sda_oe(ee_oe));

  always #10 mclk = ~mclk;

  // Hang ceiling; also counts cycles the primary holds the clock low
  always @(posedge mclk)
  begin
    cyc++;
    busy += int'(scl_oe !== 1'b0);
    if (cyc == 80000)
    begin
      fail_count++;
      finish_test();
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic do_reset(input logic [1:0] s);
    reset_n <= 1'b0;
    mode_strap <= s;
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (10) @(posedge mclk);
  endtask

  // One quarter bit with both lines held
  task automatic qtr(input logic scl_low, input logic sda_low);
    m_scl <= scl_low;
    m_sda <= sda_low;
    repeat (10) @(posedge mclk);
  endtask

  task automatic start();
    qtr(1'b1, 1'b0);
    qtr(1'b0, 1'b0);
    qtr(1'b0, 1'b1);
    qtr(1'b1, 1'b1);
  endtask

  task automatic stop();
    qtr(1'b1, 1'b1);
    qtr(1'b0, 1'b1);
    qtr(1'b0, 1'b0);
  endtask

  // Eight bits plus the acknowledge slot, MSB first
  task automatic xfer(input logic [8:0] d, output logic [8:0] r);
    for (int i = 8; i >= 0; i--)
    begin
      qtr(1'b1, !d[i]);
      qtr(1'b0, !d[i]);
      r[i] = sda;
      qtr(1'b0, !d[i]);
      qtr(1'b1, !d[i]);
    end
  endtask

  // Secondary accesses; only issued while no load runs, so no arbitration
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
    logic [8:0] r0, r1, r2;
    start();
    xfer({esl_pkg::SEC_ADDR_DEF, 2'b01}, r0);
    xfer({a, 1'b1}, r1);
    xfer({v, 1'b1}, r2);
    stop();
    check({5'h0, r0[0], r1[0], r2[0]}, 8'h00);
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [7:0] v);
    logic [8:0] r0, r1, r2, r3;
    start();
    xfer({esl_pkg::SEC_ADDR_DEF, 2'b01}, r0);
    xfer({a, 1'b1}, r1);
    start();
    xfer({esl_pkg::SEC_ADDR_DEF, 2'b11}, r2);
    xfer(9'h1ff, r3);
    stop();
    check({5'h0, r0[0], r1[0], r2[0]}, 8'h00);
    v = r3[8:1];
  endtask

  function automatic logic [6:0] exp_blk(input logic [7:0] v, input logic pd);
    return v[7] ? v[6:0] : (pd ? 7'h00 : 7'h7f);
  endfunction

  initial
  begin
    logic [7:0] v;
    for (int i = 0; i < 256; i++)
      esl_ee_model_inst.mem[i] = 8'($random(seed));
    esl_ee_model_inst.mem[5][7] = 1'b1;
    rx_dis <= 1'($random(seed));
    do_reset(esl_pkg::MODE_L1);
    check(8'(blk_en_a), 8'h7f);
    check(8'(bias_ctrl), 8'h04);
    check({7'h0, load_done_n}, 8'h01);
    check({7'h0, rx_det_en}, {7'h0, !rx_dis});
    // Override gating: corner patterns, then random ones
    for (int i = 0; i < 5; i++)
    begin
      v = (i == 0) ? 8'h80 : (i == 1) ? 8'hff : (i == 2) ? 8'h7f : 8'($random(seed));
      pd_a <= (i == 2) ? 1'b1 : 1'($random(seed));
      pd_b <= 1'($random(seed));
      reg_wr(esl_pkg::REG_PD_OVR, v);
      check(8'(blk_en_a), 8'(exp_blk(v, pd_a)));
      check(8'(blk_en_b), 8'(exp_blk(v, pd_b)));
      reg_rd(esl_pkg::REG_PD_OVR, rv);
      check(rv, v);
    end
    reg_wr(esl_pkg::REG_BIAS, 8'h08);
    check(8'(bias_ctrl), 8'(esl_pkg::BIAS_BEST));
    reg_rd(esl_pkg::REG_BIAS, rv);
    check(rv, 8'h08);
    reg_rd(8'h07, rv);
    check(rv, 8'h00);
    busy = 0;
    repeat (500) @(posedge mclk);
    check(8'(busy > 0), 8'h00);
    // Load on request, then compare against the EEPROM image
    load_req_n <= 1'b0;
    for (int i = 0; i < 20000 && load_done_n !== 1'b0; i++)
      @(posedge mclk);
    check({7'h0, load_done_n}, 8'h00);
    check(8'(blk_en_a), {1'b0, esl_ee_model_inst.mem[5][6:0]});
    check(8'(bias_ctrl), {5'h0, esl_ee_model_inst.mem[6][5:3]});
    reg_rd(esl_pkg::REG_BIAS, rv);
    check(rv, esl_ee_model_inst.mem[6]);
    // A fresh request after completion must not reload
    esl_ee_model_inst.mem[5] = ~esl_ee_model_inst.mem[5];
    load_req_n <= 1'b1;
    repeat (20) @(posedge mclk);
    load_req_n <= 1'b0;
    busy = 0;
    repeat (3000) @(posedge mclk);
    check(8'(busy > 0), 8'h00);
    check(8'(blk_en_b), {1'b0, ~esl_ee_model_inst.mem[5][6:0]});
    // Other strap codes never start the primary
    pd_b <= !pd_a; // Halves differ while the pins rule
    for (int s = 0; s < 4; s++)
      if (2'(s) != esl_pkg::MODE_L1)
      begin
        do_reset(2'(s));
        busy = 0;
        repeat (3000) @(posedge mclk);
        check(8'(busy > 0), 8'h00);
        check({7'h0, load_done_n}, 8'h01);
      end
    // Request tied low across a reset: loads unaided
    do_reset(esl_pkg::MODE_L1);
    repeat (16000) @(posedge mclk);
    check({7'h0, load_done_n}, 8'h00);
    check(8'(bias_ctrl), {5'h0, esl_ee_model_inst.mem[6][5:3]});
    finish_test();
  end
endmodule // tb_esl_top
